/* logic/rtcos_pkg.sv */
// Constants, field layouts and carriers of the timekeeper control block
package rtcos_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_LO = 8'h04;
  localparam logic [7:0] ADDR_CNT_HI = 8'h08;
  localparam logic [7:0] ADDR_MAT_LO = 8'h0C;
  localparam logic [7:0] ADDR_MAT_HI = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ==========================================================
  // Widths and counts
  localparam int CNT_W = 40;
  localparam int HI_W = 8;
  localparam int PRESC_W = 6;
  localparam logic [PRESC_W-1:0] PRESC_LAST = 6'h3F;
  localparam int RST_DLY = 2;
  localparam int NUM_EVT = 2;
  localparam int EVT_MATCH = 0;
  localparam int EVT_CLEAR = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;
  localparam logic [NUM_EVT-1:0] EVT_RESET = 2'h0;
  localparam logic [1:0] MODE_ZERO = 2'h0;

  // ==========================================================
  // Control/status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic tk_rst;
    logic cnt_en;
    logic match_wake_enable;
    logic [1:0] osc_gain_field;
    logic clr_on_match;
    logic cnt_rst_n;
    logic osc_sel;
  } rtcos_ctrl_t;

  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic [7:0] addr;
  } rtcos_ahb_req_t;

endpackage

/* logic/rtcos_top.sv */
// Timekeeper counter, match outputs and oscillator source selection
`timescale 1ns/100ps
// How it works
// R1: Setting the timekeeper reset bit holds the counter logic in reset, released two cycles after clear.
// R2: The counter advances only with count enable set and reset released, first after 64 RTC edges.
// R3: Clearing count enable stops the prescaler and freezes the counter value.
// R4: Counter writes are taken only while counting is disabled; software disables first.
// R5: With match wake enabled both match outputs are high while counter equals match value and the timekeeper is out of reset.
// R6: With match wake disabled both match outputs stay low.
// R7: The gain field drives the oscillator mode outputs and is the mode only in forced mode; reset 00.
// R8: With clear-on-match set the counter clears at its increment when equal to match, else it runs on.
// R9: Clear-on-match is suppressed while the whole match value is zero.
// R10: Writing 0 to the active-low counter reset bit holds the 40-bit counter at zero; reset 0.
// R11: Oscillator enable bit 0 makes the enable follow core supply and ignores the gain field.
// R12: Oscillator enable bit 1 forces the oscillator on with mode from the gain field.
// R13: The source select picks mode source and gates enable; at 0 mode comes from fabric inputs.
// R14: Fabric mode inputs read as zero while in standby.
// R15: The oscillator enable output high switches the crystal oscillator on.
// R16: The full 40-bit counter is compared with the full 40-bit match value every cycle.
module rtcos_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timekeeper_clock,
  input wire logic core_supply_present,
  input wire logic standby,
  input wire logic [1:0] fabric_mode,
  output logic match_out,
  output logic power_monitor_match_out,
  output logic [1:0] timekeeper_osc_mode_out,
  output logic timekeeper_osc_select_out,
  output logic osc_enable,
  output logic [1:0] osc_mode,
  output logic irq
);
  import rtcos_pkg::*;

  rtcos_ctrl_t ctrl;
  rtcos_ahb_req_t req;
  logic [RST_DLY-1:0] rst_pipe;
  logic rtc_held;
  logic run;
  logic tk_clk_q;
  logic tk_edge;
  logic [PRESC_W-1:0] presc;
  logic inc;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] match_val;
  logic hit;
  logic hit_q;
  logic mat_zero;
  logic clr_now;
  logic cnt_clear;
  logic cnt_wr;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] irq_stat;
  logic [NUM_EVT-1:0] irq_mask;
  logic [31:0] rd_mux;
  logic wr_ok;

  // ==========================================================
  // Timekeeper reset release
  // R1: bit sets hold at once, clear releases late
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= '0;
    end else begin
      rst_pipe <= {rst_pipe[RST_DLY-2:0], ctrl.tk_rst};
    end
  end
  assign rtc_held = ctrl.tk_rst | rst_pipe[RST_DLY-1];

  // ==========================================================
  // Prescaler on timekeeper clock edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tk_clk_q <= 1'b0;
    end else begin
      tk_clk_q <= timekeeper_clock;
    end
  end
  assign tk_edge = timekeeper_clock & ~tk_clk_q;
  // R2: runs only when enabled and out of reset
  assign run = ctrl.cnt_en & ~rtc_held;

  // R3: disable stops and clears the prescaler
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= '0;
    end else if (!run) begin
      presc <= '0;
    end else if (tk_edge) begin
      presc <= presc + 6'h1;
    end
  end
  // R2: increment on the 64th edge
  assign inc = run & tk_edge & (presc == PRESC_LAST);

  // ==========================================================
  // Counter and match compare
  // R16: full-width compare every cycle
  assign hit = (counter == match_val);
  assign mat_zero = (match_val == CNT_RESET);
  // R8: clear at the increment when equal
  // R9: not while match value is zero
  assign clr_now = ctrl.clr_on_match & hit & ~mat_zero;
  // R10: active-low bit holds counter cleared
  assign cnt_clear = rtc_held | ~ctrl.cnt_rst_n;
  assign wr_ok = req.valid & req.write & req.mapped;
  // R4: writes ignored while counting enabled
  assign cnt_wr = wr_ok & ~ctrl.cnt_en &
                  ((req.addr == ADDR_CNT_LO) | (req.addr == ADDR_CNT_HI));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter <= CNT_RESET;
    end else if (cnt_clear) begin
      counter <= CNT_RESET;
    end else if (cnt_wr) begin
      if (req.addr == ADDR_CNT_LO) begin
        counter[31:0] <= hwdata;
      end else begin
        counter[CNT_W-1:32] <= hwdata[HI_W-1:0];
      end
    end else if (inc) begin
      if (clr_now) begin
        counter <= CNT_RESET;
      end else begin
        counter <= counter + 40'h00_0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_val <= CNT_RESET;
    end else if (wr_ok && req.addr == ADDR_MAT_LO) begin
      match_val[31:0] <= hwdata;
    end else if (wr_ok && req.addr == ADDR_MAT_HI) begin
      match_val[CNT_W-1:32] <= hwdata[HI_W-1:0];
    end
  end

  // ==========================================================
  // Match outputs
  // R5: high on equality when wake enabled and out of timekeeper reset
  // R6: low at all times when disabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_q <= 1'b0;
      match_out <= 1'b0;
      power_monitor_match_out <= 1'b0;
    end else begin
      hit_q <= hit & ~rtc_held;
      match_out <= ctrl.match_wake_enable & hit & ~rtc_held;
      power_monitor_match_out <= ctrl.match_wake_enable & hit & ~rtc_held;
    end
  end

  // ==========================================================
  // Oscillator source selection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timekeeper_osc_mode_out <= MODE_ZERO;
      timekeeper_osc_select_out <= 1'b0;
      osc_enable <= 1'b0;
      osc_mode <= MODE_ZERO;
    end else begin
      // R7: gain field drives mode outputs
      timekeeper_osc_mode_out <= ctrl.osc_gain_field;
      timekeeper_osc_select_out <= ctrl.osc_sel;
      if (ctrl.osc_sel) begin
        // R12: forced on, gain field as mode
        // R15: enable high turns oscillator on
        osc_enable <= 1'b1;
        osc_mode <= ctrl.osc_gain_field;
      end else begin
        // R11: enable follows core supply
        // R13: mode from fabric inputs
        osc_enable <= core_supply_present;
        // R14: fabric mode zero in standby
        osc_mode <= standby ? MODE_ZERO : fabric_mode;
      end
    end
  end

  // ==========================================================
  // Interrupt status and mask
  assign evt[EVT_MATCH] = hit & ~hit_q & ~rtc_held;
  assign evt[EVT_CLEAR] = inc & clr_now & ~cnt_clear & ~cnt_wr;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi = gi + 1) begin : g_evt
      // Set wins over write-one-to-clear
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_stat[gi] <= 1'b0;
        end else if (evt[gi]) begin
          irq_stat[gi] <= 1'b1;
        end else if (wr_ok && req.addr == ADDR_IRQ_STAT && hwdata[gi]) begin
          irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= EVT_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_ok && req.addr == ADDR_IRQ_MASK) begin
        irq_mask <= hwdata[NUM_EVT-1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ok && req.addr == ADDR_CTRL) begin
      ctrl <= hwdata[7:0];
    end
  end

  // ==========================================================
  // AHB-Lite slave
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (req.mapped) begin
      unique case (req.addr)
        ADDR_CTRL: rd_mux = {24'h00_0000, ctrl};
        ADDR_CNT_LO: rd_mux = counter[31:0];
        ADDR_CNT_HI: rd_mux = {24'h00_0000, counter[CNT_W-1:32]};
        ADDR_MAT_LO: rd_mux = match_val[31:0];
        ADDR_MAT_HI: rd_mux = {24'h00_0000, match_val[CNT_W-1:32]};
        ADDR_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat};
        ADDR_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else if (req.valid && !req.write && !hreadyout) begin
      hrdata <= rd_mux;
      hreadyout <= 1'b1;
      req <= '0;
    end else if (hsel && hready && htrans[1]) begin
      req.valid <= 1'b1;
      req.write <= hwrite;
      req.addr <= haddr[7:0];
      req.mapped <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
      hreadyout <= hwrite;
    end else begin
      req <= '0;
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [6:0] edges_seen;
  logic inc_seen;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edges_seen <= 7'h00;
      inc_seen <= 1'b0;
    end else if (!run) begin
      edges_seen <= 7'h00;
      inc_seen <= 1'b0;
    end else begin
      if (tk_edge && edges_seen != 7'h7F) begin
        edges_seen <= edges_seen + 7'h01;
      end
      if (inc) begin
        inc_seen <= 1'b1;
      end
    end
  end

  sequence s_rst_dropped;
    $fell(ctrl.tk_rst) ##1 !ctrl.tk_rst;
  endsequence
  sequence s_held_then_free;
    rtc_held ##1 !rtc_held;
  endsequence

  chk_rst_release: assert property (s_rst_dropped |-> s_held_then_free) // R1
    else $error("timekeeper reset release not two cycles");
  chk_count_gate: assert property (!inc && !cnt_clear && !cnt_wr |=> $stable(counter)) // R2
    else $error("counter advanced outside an increment");
  chk_first_inc: assert property (inc && !inc_seen |-> edges_seen == 7'h3F) // R2
    else $error("first increment not on 64th edge");
  chk_stop_hold: assert property (!run && !cnt_clear && !cnt_wr |=> $stable(counter)) // R3
    else $error("counter moved while disabled");
  chk_wr_blocked: assert property (wr_ok && ctrl.cnt_en && !inc && !cnt_clear
    |=> $stable(counter)) // R4
    else $error("counter write taken while counting");
  chk_match_on: assert property (ctrl.match_wake_enable && hit && !rtc_held
    |=> match_out && power_monitor_match_out) // R5
    else $error("match outputs not high on equality");
  chk_match_off: assert property (!ctrl.match_wake_enable
    |=> !match_out && !power_monitor_match_out) // R6
    else $error("match outputs high while wake disabled");
  chk_gain_out: assert property (1'b1 |=> timekeeper_osc_mode_out == $past(ctrl.osc_gain_field)) // R7
    else $error("mode outputs do not follow gain field");
  chk_clr_match: assert property (inc && clr_now && !cnt_clear && !cnt_wr
    |=> counter == CNT_RESET) // R8
    else $error("counter not cleared on match");
  chk_clr_zero: assert property (inc && mat_zero && !cnt_clear && !cnt_wr
    |=> counter == $past(counter) + 40'h00_0000_0001) // R9
    else $error("clear on match acted with zero match value");
  chk_cnt_reset: assert property (!ctrl.cnt_rst_n |=> counter == CNT_RESET) // R10
    else $error("counter not held by reset bit");
  chk_osc_follow: assert property (!ctrl.osc_sel |=> osc_enable == $past(core_supply_present)
    && osc_mode == ($past(standby) ? MODE_ZERO : $past(fabric_mode))) // R11
    else $error("oscillator not following core supply and fabric mode");
  chk_osc_forced: assert property (ctrl.osc_sel
    |=> osc_enable && osc_mode == $past(ctrl.osc_gain_field)) // R12
    else $error("oscillator not forced with gain mode");
  chk_stby_mode: assert property (!ctrl.osc_sel && standby |=> osc_mode == MODE_ZERO) // R14
    else $error("fabric mode not zero in standby");
  chk_hold_zero: assert property (rtc_held |=> counter == CNT_RESET) // R1
    else $error("counter not cleared during timekeeper reset");
  chk_sel_out: assert property (1'b1 |=> timekeeper_osc_select_out == $past(ctrl.osc_sel)) // R13
    else $error("select output does not follow control bit");

  sequence s_rd_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_rd_answered;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_read_wait: assert property (s_rd_taken |=> s_rd_answered)
    else $error("read answer not after one wait state");
  chk_write_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write data phase not zero wait");
  chk_irq_level: assert property (1'b1 |=> irq == $past(|(irq_stat & irq_mask)))
    else $error("interrupt not following masked status");
  chk_set_wins: assert property (evt[EVT_MATCH] |=> irq_stat[EVT_MATCH])
    else $error("match event lost against clear");
  chk_clr_event: assert property (evt[EVT_CLEAR] |=> irq_stat[EVT_CLEAR])
    else $error("clear event not recorded");
  chk_stat_clear: assert property (wr_ok && req.addr == ADDR_IRQ_STAT && hwdata[EVT_MATCH]
    && !evt[EVT_MATCH] |=> !irq_stat[EVT_MATCH])
    else $error("status bit not cleared by write of one");

endmodule

/* test/rtcos_osc_model.sv */
// Crystal oscillator and regulator wake monitor model
`timescale 1ns/100ps
module rtcos_osc_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic osc_enable,
  input wire logic power_monitor_match_out,
  output logic timekeeper_clock,
  output logic wake_seen
);
  logic [1:0] half_cnt;
  // ==========================================
  // Oscillator
  // runs only when enabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt <= 2'h0;
      timekeeper_clock <= 1'b0;
    end else if (osc_enable) begin
      half_cnt <= half_cnt + 2'h1;
      if (half_cnt[0]) begin
        timekeeper_clock <= ~timekeeper_clock;
      end
    end
  end
  // ==========================================
  // Regulator monitor
  // match turns regulator on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_seen <= 1'b0;
    end else if (power_monitor_match_out) begin
      wake_seen <= 1'b1;
    end
  end
endmodule

/* test/rtcos_top_bench.sv */
// Register-level bench of the timekeeper control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module rtcos_top_bench;
  import rtcos_pkg::*;
  logic ref_clk, rst_n, hwrite, hready, core_supply_present, standby, timekeeper_clock;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans, fabric_mode, timekeeper_osc_mode_out, osc_mode;
  logic hreadyout, hresp, match_out, power_monitor_match_out;
  logic timekeeper_osc_select_out, osc_enable, irq, wake_seen;
  int failures, comparisons;
  assign hready = hreadyout;
  rtcos_top i_rtcos_top (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timekeeper_clock(timekeeper_clock), .core_supply_present(core_supply_present),
    .standby(standby), .fabric_mode(fabric_mode), .match_out(match_out),
    .power_monitor_match_out(power_monitor_match_out),
    .timekeeper_osc_mode_out(timekeeper_osc_mode_out),
    .timekeeper_osc_select_out(timekeeper_osc_select_out), .osc_enable(osc_enable),
    .osc_mode(osc_mode), .irq(irq));
  rtcos_osc_model i_rtcos_osc_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .osc_enable(osc_enable), .power_monitor_match_out(power_monitor_match_out),
    .timekeeper_clock(timekeeper_clock), .wake_seen(wake_seen));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Tasks
  task automatic summarize();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("ERROR hreadyout expected 1 seen %b", hreadyout);
      summarize();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rdat = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(n, e, rdat)
  endtask
  task automatic wait_match(input logic lvl);
    int n;
    for (n = 0; n < 3000 && match_out !== lvl; n++) begin
      @(posedge ref_clk);
    end
    if (n >= 3000) begin
      failures++;
      $display("ERROR match_out expected %b seen %b", lvl, match_out);
      summarize();
    end
  endtask
  // ==========================================
  // Tests
  initial begin
    logic [1:0] g;
    logic s;
    rst_n = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    core_supply_present = 1'b1;
    standby = 1'b0;
    fabric_mode = 2'h0;
    failures = 0;
    comparisons = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(ADDR_CTRL, 32'h0000_0000, "ctrl reset");
    rdchk(8'h1C, 32'h0000_0000, "unmapped");
    `CHK("hresp okay", 1'b0, hresp)
    $display("reset test done");
    wr(ADDR_MAT_LO, 32'h0000_0003);
    wr(ADDR_MAT_HI, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0063);
    rdchk(ADDR_CNT_LO, 32'h0000_0000, "cnt early");
    wait_match(1'b1);
    wr(ADDR_CTRL, 32'h0000_0023);
    repeat (300) @(posedge ref_clk);
    rdchk(ADDR_CNT_LO, 32'h0000_0003, "cnt frozen");
    `CHK("psm match", 1'b1, power_monitor_match_out)
    `CHK("wake seen", 1'b1, wake_seen)
    rdchk(ADDR_IRQ_STAT, 32'h0000_0001, "stat match");
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    `CHK("irq set", 1'b1, irq)
    wr(ADDR_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    `CHK("irq clear", 1'b0, irq)
    wr(ADDR_MAT_HI, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    `CHK("match hi", 1'b0, match_out)
    wr(ADDR_MAT_HI, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0003);
    repeat (3) @(posedge ref_clk);
    `CHK("wake off", 1'b0, match_out)
    `CHK("wake off psm", 1'b0, power_monitor_match_out)
    wr(ADDR_CTRL, 32'h0000_00A3);
    rdchk(ADDR_CNT_LO, 32'h0000_0000, "rtc reset cnt");
    `CHK("rtc reset match", 1'b0, match_out)
    $display("count test done");
    wr(ADDR_CTRL, 32'h0000_0003);
    wr(ADDR_CNT_LO, 32'h0000_0010);
    rdchk(ADDR_CNT_LO, 32'h0000_0010, "cnt write off");
    wr(ADDR_CTRL, 32'h0000_0043);
    wr(ADDR_CNT_LO, 32'h0000_0020);
    wr(ADDR_CTRL, 32'h0000_0003);
    rdchk(ADDR_CNT_LO, 32'h0000_0010, "cnt write on");
    wr(ADDR_CTRL, 32'h0000_0001);
    rdchk(ADDR_CNT_LO, 32'h0000_0000, "cnt reset");
    wr(ADDR_CTRL, 32'h0000_0003);
    wr(ADDR_MAT_LO, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0047);
    repeat (400) @(posedge ref_clk);
    rdchk(ADDR_CNT_LO, 32'h0000_0001, "zero match");
    wr(ADDR_MAT_LO, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0067);
    wait_match(1'b1);
    wait_match(1'b0);
    rdchk(ADDR_CNT_LO, 32'h0000_0000, "clear on match");
    xfer(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK("stat clear", 1'b1, rdat[1])
    $display("match test done");
    for (int i = 0; i < 8; i++) begin
      s = i[2];
      g = i[1:0];
      @(posedge ref_clk);
      core_supply_present <= i[0];
      standby <= i[1];
      fabric_mode <= 2'h3 - g;
      wr(ADDR_CTRL, {27'h000_0000, g, 2'h1, s});
      repeat (3) @(posedge ref_clk);
      `CHK("gain out", g, timekeeper_osc_mode_out)
      `CHK("sel out", s, timekeeper_osc_select_out)
      `CHK("osc en", s ? 1'b1 : i[0], osc_enable)
      `CHK("osc mode", s ? g : (i[1] ? 2'h0 : 2'h3 - g), osc_mode)
    end
    $display("oscillator test done");
    summarize();
  end
endmodule
